// ===== rtl/temp_word_pkg.sv
package temp_word_pkg;

    // Width of the read word and of the temperature field.
    localparam int WORD_BITS = 16;
    localparam int TEMP_BITS = 14;
    // Bit position of the lowest temperature bit in the read word.
    localparam int TEMP_LSB = 2;
    // The two trailing bits of every read word.
    localparam logic [1:0] TAIL_BITS = 2'h3;
    // Identity pattern in the upper fourteen bits; the value is arbitrary.
    localparam logic [13:0] IDENTITY_UPPER = 14'h2a55;
    // Serial clocks in the read phase and in a whole transaction.
    localparam int READ_CLOCKS = 16;
    localparam int FRAME_CLOCKS = 32;
    // Width of the command shift register.
    localparam int CMD_BITS = 8;
    // Command codes.
    localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
    localparam logic [7:0] CMD_CONVERT = 8'h00;
    // Reset value of the mode: continuous conversion.
    localparam logic RESET_SHUTDOWN = 1'b0;
    // Width of the serial clock counter.
    localparam int COUNT_BITS = 6;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a group of pins; the first stage is read only
// by the second stage.
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Pins in and their synchronised copies out.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    // First stage, read by the second stage alone.
    logic [WIDTH-1:0] stage_one;

    // Both stages load every edge and clear to zero under reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= '0;
            pin_out   <= '0;
        end else begin
            stage_one <= pin_in;
            pin_out   <= stage_one;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/temp_sensor_read_word.sv
// Functional notes
// - Temperature in D15..D2, two's complement.
// - Bits D1 and D0 always one.
// - Shutdown sends identity word instead.
// - Identity word is fixed, low bits ones.
// - Word leaves most significant bit first.
// - First bit at select low, then falling edges.
// - Transaction is 16 read, 16 write clocks.
// - Last eight bits: FF shutdown, 00 convert.
`timescale 1ns/1ns
`default_nettype none

module temp_sensor_read_word (
    // System clock and asynchronous reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Temperature from the converter, on the clk domain.
    input  wire logic [13:0] temp_value,
    input  wire logic        temp_valid,
    // Serial link pins from the host.
    input  wire logic        chip_sel_b,
    input  wire logic        serial_clk_in,
    // Shared data line as input, output and output enable.
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_oe,
    // Current mode, high in shutdown.
    output logic             shutdown
);

    // Released reset copy.
    logic       rst_meta;
    logic       rst_sync_b;
    // Synchronised pins: select, clock, data.
    logic [2:0] pins_sync;
    logic       sel_b_s;
    logic       sclk_s;
    logic       din_s;
    // Previous synchronised levels for edge detection.
    logic       sel_b_d;
    logic       sclk_d;
    // Stored temperature reading.
    logic [15:0] temperature_reading;
    // Output shift register and clock counter.
    logic [15:0] shift_out;
    logic [5:0]  clk_count;
    // Command shift register.
    logic [7:0]  cmd_shift;

    // Link states, one-hot.
    typedef enum logic [2:0] {
        LINK_IDLE  = 3'b001,
        LINK_READ  = 3'b010,
        LINK_WRITE = 3'b100
    } link_state_t;
    link_state_t state;
    link_state_t next_state;

    // Fixed identity word.
    wire [15:0] maker_identity_word = {temp_word_pkg::IDENTITY_UPPER,
                                       temp_word_pkg::TAIL_BITS};

    // Releases reset through two flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Pins pass two flops before any logic reads them.
    // Select travels inverted, so the cleared synchroniser reads as
    // deselected and no false select edge follows reset.
    pin_sync #(
        .WIDTH (3)
    ) i_pin_sync (
        .clk     (clk),
        .rst_b   (rst_sync_b),
        .pin_in  ({~chip_sel_b, serial_clk_in, data_in}),
        .pin_out (pins_sync)
    );
    assign sel_b_s = ~pins_sync[2];
    assign sclk_s  = pins_sync[1];
    assign din_s   = pins_sync[0];

    // Edge decode of the synchronised pins.
    wire sel_fall  = sel_b_d & ~sel_b_s;
    wire sel_rise  = ~sel_b_d & sel_b_s;
    wire sclk_rise = ~sclk_d & sclk_s & ~sel_b_s;
    wire sclk_fall = sclk_d & ~sclk_s & ~sel_b_s;
    // Word chosen for loading at select low.
    wire [15:0] load_word = shutdown ? maker_identity_word
                                     : temperature_reading;
    // Read phase is over once sixteen rising edges have passed.
    wire read_done = (clk_count ==
        temp_word_pkg::COUNT_BITS'(temp_word_pkg::READ_CLOCKS));
    // Counter stops at a full transaction.
    wire frame_full = (clk_count ==
        temp_word_pkg::COUNT_BITS'(temp_word_pkg::FRAME_CLOCKS));

    // Keeps delayed pin copies.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sel_b_d <= 1'b1;
            sclk_d  <= 1'b0;
        end else begin
            sel_b_d <= sel_b_s;
            sclk_d  <= sclk_s;
        end
    end

    // Captures temperature; held while a frame runs so the word is stable.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            temperature_reading <= {14'h0000, temp_word_pkg::TAIL_BITS};
        end else if (temp_valid && state == LINK_IDLE && sel_b_s) begin
            temperature_reading <= {temp_value,
                                    temp_word_pkg::TAIL_BITS};
        end
    end

    // Next link state.
    always_comb begin
        next_state = state;
        case (state)
            LINK_IDLE: begin
                if (sel_fall) begin
                    next_state = LINK_READ;
                end
            end
            LINK_READ: begin
                if (sel_rise) begin
                    next_state = LINK_IDLE;
                end else if (read_done) begin
                    next_state = LINK_WRITE;
                end
            end
            LINK_WRITE: begin
                if (sel_rise) begin
                    next_state = LINK_IDLE;
                end
            end
            default: begin
                next_state = LINK_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Counts rising serial clocks within a frame.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            clk_count <= '0;
        end else if (sel_fall) begin
            clk_count <= '0;
        end else if (sclk_rise && !frame_full) begin
            clk_count <= clk_count + 6'h01;
        end
    end

    // Loads the word at select low and shifts on falling clock.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            shift_out <= 16'hffff;
        end else if (sel_fall) begin
            shift_out <= load_word;
        end else if (sclk_fall && state == LINK_READ) begin
            shift_out <= {shift_out[14:0], 1'b1};
        end
    end

    // Collects command bits only in the write phase.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cmd_shift <= temp_word_pkg::CMD_CONVERT;
        end else if (sel_fall) begin
            cmd_shift <= temp_word_pkg::CMD_CONVERT;
        end else if (sclk_rise && state == LINK_WRITE) begin
            cmd_shift <= {cmd_shift[6:0], din_s};
        end
    end

    // Mode update when select rises after a write phase of at least eight clocks.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            shutdown <= temp_word_pkg::RESET_SHUTDOWN;
        end else if (sel_rise && state == LINK_WRITE
                     && clk_count > 6'(temp_word_pkg::READ_CLOCKS
                                       + temp_word_pkg::CMD_BITS - 1)) begin
            if (cmd_shift == temp_word_pkg::CMD_SHUTDOWN) begin
                shutdown <= 1'b1;
            end else if (cmd_shift == temp_word_pkg::CMD_CONVERT) begin
                shutdown <= 1'b0;
            end
        end
    end

    // Drives the line during the read phase; MSB of the shifter goes out.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            data_out <= 1'b1;
            data_oe  <= 1'b0;
        end else begin
            data_out <= sel_fall ? load_word[15] : shift_out[15];
            data_oe  <= (next_state == LINK_READ);
        end
    end

    // Checks.
    bit_tail_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (state == LINK_READ && clk_count == 6'd14 && sclk_fall)
        |=> ##1 data_out)
        else $error("tail bit not one");
    id_word_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (sel_fall && shutdown) |=> shift_out
        == {temp_word_pkg::IDENTITY_UPPER, 2'b11})
        else $error("identity word not loaded");
    temp_word_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (sel_fall && !shutdown) |=> shift_out[15:2]
        == $past(temperature_reading[15:2]))
        else $error("temperature word not loaded");
    first_bit_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        sel_fall |=> data_oe && data_out == $past(load_word[15]))
        else $error("first bit not driven");
    msb_shift_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (sclk_fall && state == LINK_READ && !sel_rise)
        |=> shift_out[15] == $past(shift_out[14]))
        else $error("shift order wrong");
    phase_end_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (state == LINK_READ && read_done && !sel_rise)
        |=> state == LINK_WRITE ##1 !data_oe)
        else $error("read phase did not end");
    read_cmd_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (state == LINK_READ) |=> $stable(cmd_shift) || $past(sel_fall))
        else $error("command moved in read phase");
    cmd_off_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (sel_rise && state == LINK_WRITE && clk_count >= 6'd24
         && cmd_shift == 8'hff) |=> shutdown)
        else $error("shutdown not taken");
    idle_hiz_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        (state == LINK_IDLE && sel_b_s) |=> !data_oe)
        else $error("line driven while idle");

endmodule

`default_nettype wire

// ===== test/serial_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Behavioural serial master: reads the word, then shifts a command in.
module serial_host_model (
    // Clock used only to vary the floating line.
    input  wire logic        clk,
    // Device side of the shared line.
    input  wire logic        data_out,
    input  wire logic        data_oe,
    // Link pins driven by the host.
    output logic             chip_sel_b,
    output logic             serial_clk_in,
    output wire logic        data_in,
    // Received bits and a pulse when the read phase ends.
    output logic      [15:0] rx_word,
    output logic             rx_done
);
    logic host_oe;  // Host drives the line in the write phase.
    logic host_d;   // Bit the host drives.
    logic float_v;  // Undriven line wanders so stale data never passes.

    // Resolve the shared line from both parties' enables.
    assign data_in = data_oe ? data_out : (host_oe ? host_d : float_v);

    // Flip the floating level every cycle.
    always @(posedge clk) float_v <= ~float_v;

    initial begin
        {chip_sel_b, serial_clk_in, host_oe, host_d, float_v} = 5'h10;
        {rx_word, rx_done} = 17'h0;
    end

    // Read nr bits, then shift nw command bits if the read ran to 16.
    task automatic frame(input int nr, input int nw, input logic [15:0] cmd);
        rx_word = 16'h0;
        chip_sel_b = 1'b0;
        for (int i = 0; i < nr; i++) begin
            #63 serial_clk_in = 1'b1;
            // A bit the device does not drive counts as unknown.
            rx_word = {rx_word[14:0], data_oe ? data_in : 1'bx};
            #62 serial_clk_in = 1'b0;
        end
        rx_done = 1'b1;
        #1 rx_done = 1'b0;
        // Drive after the falling edge, once the device has let go.
        for (int i = 0; (nr == 16) && (i < nw); i++) begin
            host_oe = 1'b1;
            host_d = cmd[nw-1-i];
            #63 serial_clk_in = 1'b1;
            #62 serial_clk_in = 1'b0;
        end
        #63 chip_sel_b = 1'b1;
        #20 host_oe = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_temp_sensor_read_word.sv
`timescale 1ns/1ns
`default_nettype none

module tb_temp_sensor_read_word;
    logic        clk, rst_b, temp_valid, data_out, data_oe, shutdown;
    logic [13:0] temp_value, t;
    wire logic   chip_sel_b, serial_clk_in, data_in;
    logic [15:0] rx_word;
    logic        rx_done, mode;
    logic [16:0] notes[$];  // Expected mode and word per read.
    int          n_fail, tests_run, seed;
    logic [13:0] bounds[3] = '{14'h1fff, 14'h2000, 14'h3fff};

    // Clock toggles every half period.
    always #5 clk = ~clk;

    temp_sensor_read_word i_temp_sensor_read_word (
        .clk(clk), .rst_b(rst_b), .temp_value(temp_value),
        .temp_valid(temp_valid), .chip_sel_b(chip_sel_b),
        .serial_clk_in(serial_clk_in), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .shutdown(shutdown));

    serial_host_model i_serial_host_model (
        .clk(clk), .data_out(data_out), .data_oe(data_oe),
        .chip_sel_b(chip_sel_b), .serial_clk_in(serial_clk_in),
        .data_in(data_in), .rx_word(rx_word), .rx_done(rx_done));

    // Print counts and the verdict, then stop.
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task check(string name, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (exp !== got) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare each finished read against the oldest note.
    always @(posedge rx_done) begin : watch
        logic [16:0] n;
        n = notes.pop_front();
        check("read word", n[15:0], rx_word);
        check("mode", {15'h0, n[16]}, {15'h0, shutdown});
    end

    // Hand a new temperature to the block while the link is idle.
    task load(logic [13:0] v);
        @(posedge clk);
        #1 temp_value = v;
        temp_valid = 1'b1;
        @(posedge clk);
        #1 temp_valid = 1'b0;
    endtask

    // Note the expected word, then run one frame.
    task xfer(int nr, int nw, logic [15:0] cmd);
        logic [15:0] w;
        w = mode ? {temp_word_pkg::IDENTITY_UPPER, temp_word_pkg::TAIL_BITS}
                 : {t, temp_word_pkg::TAIL_BITS};
        notes.push_back({mode, w >> (16 - nr)});
        i_serial_host_model.frame(nr, nw, cmd);
    endtask

    // Watchdog in case the link hangs.
    initial begin
        #300000 n_fail++;
        complete_run;
    end

    initial begin
        {clk, rst_b, temp_valid, mode, temp_value, t} = '0;
        n_fail = 0;
        tests_run = 0;
        seed = 60;
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge clk);
        xfer(16, 8, 16'h0000);
        $display("reset word test done");
        for (int i = 0; i < 8; i++) begin
            t = (i < 3) ? bounds[i] : 14'($random(seed));
            load(t);
            xfer(16, 16, 16'h0000);
        end
        $display("temperature test done");
        xfer(5, 0, 16'h0000);
        $display("early abort test done");
        xfer(16, 16, 16'h00ff);
        mode = 1'b1;
        load(14'h0abc);
        xfer(16, 16, 16'h5aff);
        xfer(16, 4, 16'h0000);
        xfer(16, 8, 16'h0000);
        mode = 1'b0;
        t = 14'h0abc;
        load(t);
        xfer(16, 8, 16'h0000);
        $display("mode test done");
        complete_run;
    end
endmodule
`default_nettype wire
